// ===== core/dpll_pkg.sv
package dpll_pkg;
  // Clock rate and the one-second base of every timer
  localparam int CLK_HZ = 20_000_000;
  localparam int SECOND_S = 1;
  localparam int TICK_CYCLES = SECOND_S * CLK_HZ;
  // Times in seconds
  localparam int LOCK_HOLD_S = 2;
  localparam int INVALID_S = 2;
  localparam int TIMEOUT_S = 100;
  // Sizes
  localparam int NUM_INPUTS = 8;
  localparam int AW = 5;
  localparam int DW = 16;
  localparam int SEC_W = 16;
  // Register offsets (byte addresses)
  localparam logic [AW-1:0] ADDR_MODE_ONE = 5'h00;
  localparam logic [AW-1:0] ADDR_MODE_THREE = 5'h04;
  localparam logic [AW-1:0] ADDR_TIMEOUT = 5'h08;
  localparam logic [AW-1:0] ADDR_LATCHED_TWO = 5'h0c;
  localparam logic [AW-1:0] ADDR_OPSTATUS = 5'h10;
  localparam logic [AW-1:0] ADDR_VALID = 5'h14;
  localparam logic [AW-1:0] ADDR_ALARMS = 5'h18;
  // Field positions
  localparam int FORCE_CODE_LSB = 0;
  localparam int FORCE_GO_BIT = 3;
  localparam int LOCK_EN_BIT = 4;
  localparam int REVERT_BIT = 0;
  localparam int STCHG_BIT = 0;
  // Reset values
  localparam logic [2:0] FORCE_CODE_RST = 3'h0;
  localparam logic LOCK_EN_RST = 1'b0;
  localparam logic REVERT_RST = 1'b0;
  localparam logic [SEC_W-1:0] TIMEOUT_RST = 16'h0064;
  // Counter thresholds in ticks
  localparam logic [SEC_W-1:0] LOCK_HOLD_T = SEC_W'(LOCK_HOLD_S);
  localparam logic [SEC_W-1:0] INVALID_T = SEC_W'(INVALID_S);
  // Timing states, codes shared by force field and state field
  typedef enum logic [2:0] {
    ST_FREE, ST_PRE, ST_LOCKED, ST_LOL, ST_PRE2, ST_HOLD
  } tstate_t;
  localparam logic [2:0] NUM_STATES = 3'h6;
endpackage

// ===== core/dpll_state_ctrl.sv
//Contract
// - Six states: three modes, three temporary
// - Software may force the current state
// - Every state change sets sticky flag
// - Current state readable in status register
// - Reset enters free-run, outputs from oscillator
// - Free-run to prelocked when input valid
// - Prelocked: 2 s lock within timeout
// - Prelocked timeout: alarm, invalidate, retry other
// - Prelocked to free-run, nothing valid 2 s
// - Revertive: better input restarts prelocked
// - Valid means no activity or lock alarm
// - Locked outputs follow the selected reference
// - Lock pin high in locked when enabled
// - Locked activity loss: prelocked2 or holdover
// - Loss of lock in locked: loss-of-lock
// - Loss-of-lock relocks for 2 s: locked
// - Loss-of-lock activity loss: wait 2 s
// - Loss-of-lock timeout: alarm, prelocked2 or holdover
// - Prelocked2: 2 s lock within timeout
// - Prelocked2 timeout: alarm, retry or holdover
// - Revertive: better input restarts prelocked2
// - Holdover to prelocked2 on any valid
// - Selector picks highest priority valid input
// - Fast switch goes straight to prelocked2
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module dpll_state_ctrl
  import dpll_pkg::*;
#(
  parameter int N = dpll_pkg::NUM_INPUTS,
  parameter int TICK = dpll_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic [dpll_pkg::AW-1:0] ADDR,
  input wire logic [dpll_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [dpll_pkg::DW-1:0] RDATA,
  // Clock monitors and lock detectors
  input wire logic [N-1:0] ACT_ALARM,
  input wire logic PHASE_LOCK,
  input wire logic LOSS_OF_LOCK,
  input wire logic FAST_FAIL,
  // State and mode outputs
  output logic LOCK,
  output logic [2:0] STATE,
  output logic [$clog2(N)-1:0] SEL_REF,
  output logic [N-1:0] INPUT_VALID,
  output logic TRACK_REF,
  output logic HOLDOVER,
  output logic FREE_RUN
);
  import dpll_pkg::*;

  localparam int IW = $clog2(N);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  tstate_t state_q, state_d; // Timing state
  logic [2:0] force_code_q; // Last written force code, read back
  logic lock_en_q; // Lock pin enable
  logic revert_q; // Revertive selection
  logic [SEC_W-1:0] timeout_q; // Acquire timeout in seconds
  logic stchg_q; // Sticky state-change flag
  logic [N-1:0] palarm_q; // Sticky phase-lock alarms
  logic [SEC_W-1:0] to_cnt_q; // Seconds spent acquiring
  logic [SEC_W-1:0] lock_cnt_q; // Seconds of continuous phase lock
  logic [SEC_W-1:0] inv_cnt_q; // Seconds with reference invalid
  logic lolto_q; // Loss-of-lock phase timed out
  logic lock_q, track_q, hold_q, free_q; // Registered pin outputs
  logic [DW-1:0] rdata_q; // Read data
  logic tick; // One-second enable
  logic [IW-1:0] sel_idx; // Selected reference
  logic sel_chg; // Selection moved last cycle
  logic sel_ok; // Selected reference valid
  logic other_valid; // Some other input valid
  logic [N-1:0] valid; // Per-input validity

  ////////////////////////////////////////////////////////////////////////
  // One-second time base
  sec_tick #(.CYCLES(TICK)) u_tick (
    .clk(CLK),
    .rst(RST),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Validity and reference selection
  assign valid = ~ACT_ALARM & ~palarm_q;
  wire any_valid = |valid;
  // Hold the failed reference during loss-of-lock so the 2 s wait
  // measures that reference and not its replacement
  wire sel_hold = (state_q == ST_LOL);

  ref_select #(.N(N), .IW(IW)) u_sel (
    .clk(CLK),
    .rst(RST),
    .valid(valid),
    .revert(revert_q),
    .hold(sel_hold),
    .sel_q(sel_idx),
    .changed_q(sel_chg),
    .sel_ok(sel_ok),
    .other_valid(other_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  wire hit_one = (ADDR == ADDR_MODE_ONE);
  wire hit_three = (ADDR == ADDR_MODE_THREE);
  wire hit_to = (ADDR == ADDR_TIMEOUT);
  wire hit_lat = (ADDR == ADDR_LATCHED_TWO);
  wire hit_op = (ADDR == ADDR_OPSTATUS);
  wire hit_val = (ADDR == ADDR_VALID);
  wire hit_alm = (ADDR == ADDR_ALARMS);
  wire wr_one = WR && hit_one;
  wire wr_three = WR && hit_three;
  wire wr_to = WR && hit_to;
  wire wr_lat = WR && hit_lat;
  wire wr_alm = WR && hit_alm;
  wire [2:0] wr_code = WDATA[FORCE_CODE_LSB +: 3];
  // Force only with the go bit set and a code that names a state
  wire force_req = wr_one && WDATA[FORCE_GO_BIT] &&
                   (wr_code < NUM_STATES);
  wire stchg_clr = wr_lat && WDATA[STCHG_BIT];
  wire [N-1:0] alm_clr = wr_alm ? WDATA[N-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////
  // Timer conditions
  wire in_acq = (state_q == ST_PRE) || (state_q == ST_PRE2) ||
                (state_q == ST_LOL);
  // A zero timeout expires at once, every cycle it is seen
  wire to_hit = in_acq && (to_cnt_q >= timeout_q);
  wire lock_ok = (lock_cnt_q >= LOCK_HOLD_T);
  wire inv_ok = (inv_cnt_q >= INVALID_T);
  wire st_chg = (state_d != state_q);
  wire clr_tmr = st_chg || sel_chg || to_hit;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_FREE: begin
        if (any_valid) begin
          state_d = ST_PRE;
        end
      end
      ST_PRE: begin
        if (lock_ok && sel_ok) begin
          state_d = ST_LOCKED;
        end else if (!any_valid && inv_ok) begin
          state_d = ST_FREE;
        end
      end
      ST_LOCKED: begin
        if (FAST_FAIL) begin
          state_d = ST_PRE2;
        end else if (!sel_ok && other_valid) begin
          state_d = ST_PRE2;
        end else if (!sel_ok && inv_ok) begin
          state_d = ST_HOLD;
        end else if (LOSS_OF_LOCK) begin
          state_d = ST_LOL;
        end
      end
      ST_LOL: begin
        if (FAST_FAIL) begin
          state_d = ST_PRE2;
        end else if (lock_ok && sel_ok) begin
          state_d = ST_LOCKED;
        end else if (!sel_ok && lolto_q && other_valid) begin
          state_d = ST_PRE2;
        end else if (!sel_ok && inv_ok) begin
          // Activity loss or timeout with nothing else valid
          state_d = other_valid ? ST_PRE2 : ST_HOLD;
        end
      end
      ST_PRE2: begin
        if (lock_ok && sel_ok) begin
          state_d = ST_LOCKED;
        end else if (!any_valid && inv_ok) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (any_valid) begin
          state_d = ST_PRE2;
        end
      end
      default: begin
        state_d = ST_FREE;
      end
    endcase
    // Software force overrides the automatic choice
    if (force_req) begin
      state_d = tstate_t'(wr_code);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_FREE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acquire timeout counter; restarting on a new selection gives the
  // retry on an alternate or better input a full period
  always_ff @(posedge CLK) begin
    if (RST || clr_tmr || !in_acq) begin
      to_cnt_q <= '0;
    end else if (tick && (to_cnt_q != '1)) begin
      to_cnt_q <= to_cnt_q + 1'b1;
    end
  end

  // Continuous phase-lock seconds; any drop of lock starts over
  always_ff @(posedge CLK) begin
    if (RST || clr_tmr || !PHASE_LOCK) begin
      lock_cnt_q <= '0;
    end else if (tick && !lock_ok) begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  // Seconds with the selected reference invalid
  always_ff @(posedge CLK) begin
    if (RST || st_chg || sel_ok) begin
      inv_cnt_q <= '0;
    end else if (tick && !inv_ok) begin
      inv_cnt_q <= inv_cnt_q + 1'b1;
    end
  end

  // Remember a timeout in loss-of-lock until the state moves on
  always_ff @(posedge CLK) begin
    if (RST || st_chg) begin
      lolto_q <= 1'b0;
    end else if (to_hit && (state_q == ST_LOL)) begin
      lolto_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase-lock alarms: set on timeout for the selected input, cleared
  // by writing ones; a set in the same cycle wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_alarm
      wire set_a = to_hit && (sel_idx == IW'(gi));
      always_ff @(posedge CLK) begin
        if (RST) begin
          palarm_q[gi] <= 1'b0;
        end else if (set_a) begin
          palarm_q[gi] <= 1'b1;
        end else if (alm_clr[gi]) begin
          palarm_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      force_code_q <= FORCE_CODE_RST;
      lock_en_q <= LOCK_EN_RST;
      revert_q <= REVERT_RST;
      timeout_q <= TIMEOUT_RST;
    end else begin
      if (wr_one) begin
        force_code_q <= wr_code;
        lock_en_q <= WDATA[LOCK_EN_BIT];
      end
      if (wr_three) begin
        revert_q <= WDATA[REVERT_BIT];
      end
      if (wr_to) begin
        timeout_q <= WDATA[SEC_W-1:0];
      end
    end
  end

  // Sticky state-change flag; set wins over a clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      stchg_q <= 1'b0;
    end else if (st_chg) begin
      stchg_q <= 1'b1;
    end else if (stchg_clr) begin
      stchg_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: data stand only in the cycle after the strobe
  wire [DW-1:0] rd_one = DW'({lock_en_q, 1'b0, force_code_q});
  wire [DW-1:0] rd_three = DW'(revert_q);
  wire [DW-1:0] rd_lat = DW'(stchg_q);
  wire [DW-1:0] rd_op = DW'(state_q);
  wire [DW-1:0] rd_val = DW'(valid);
  wire [DW-1:0] rd_alm = DW'({ACT_ALARM, palarm_q});
  wire [DW-1:0] rd_mux = hit_one ? rd_one :
                         hit_three ? rd_three :
                         hit_to ? timeout_q :
                         hit_lat ? rd_lat :
                         hit_op ? rd_op :
                         hit_val ? rd_val :
                         hit_alm ? rd_alm : '0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= RD ? rd_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode outputs for the datapath; one cycle behind the state
  wire is_track = ((state_q == ST_LOCKED) || (state_q == ST_PRE) ||
                   (state_q == ST_PRE2) || (state_q == ST_LOL)) && sel_ok;
  always_ff @(posedge CLK) begin
    if (RST) begin
      lock_q <= 1'b0;
      track_q <= 1'b0;
      hold_q <= 1'b0;
      free_q <= 1'b1;
    end else begin
      lock_q <= lock_en_q && (state_q == ST_LOCKED);
      track_q <= is_track;
      // Temporary holdover while the reference is bad
      hold_q <= (state_q == ST_HOLD) ||
                (!is_track && (state_q != ST_FREE));
      free_q <= (state_q == ST_FREE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output wiring
  assign RDATA = rdata_q;
  assign LOCK = lock_q;
  assign STATE = state_q;
  assign SEL_REF = sel_idx;
  assign INPUT_VALID = valid;
  assign TRACK_REF = track_q;
  assign HOLDOVER = hold_q;
  assign FREE_RUN = free_q;
endmodule
`default_nettype wire

// ===== core/ref_select.sv
`timescale 1ns/10ps
`default_nettype none
// Reference selector: lowest index is highest priority
module ref_select #(
  parameter int N = 8,
  parameter int IW = $clog2(N)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic [N-1:0] valid,
  input wire logic revert,
  input wire logic hold,
  // Selection
  output logic [IW-1:0] sel_q,
  output logic changed_q,
  output logic sel_ok,
  output logic other_valid
);
  logic [IW-1:0] best; // Highest priority valid input
  logic [N-1:0] lower; // Any valid input at a lower index
  logic [N-1:0] sel_hot; // One-hot of the selection

  ////////////////////////////////////////////////////////////////////////
  // Priority chain, one stage per input
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_chain
      if (i == 0) begin : g_first
        assign lower[i] = 1'b0;
      end else begin : g_rest
        assign lower[i] = lower[i-1] | valid[i-1];
      end
      assign sel_hot[i] = (sel_q == IW'(i));
    end
  endgenerate

  // Encode the first valid input
  always_comb begin
    best = '0;
    for (int k = 0; k < N; k++) begin
      if (valid[k] && !lower[k]) begin
        best = IW'(k);
      end
    end
  end

  wire any_valid = |valid;
  assign sel_ok = |(valid & sel_hot);
  assign other_valid = |(valid & ~sel_hot);
  // Switch when the selection failed, or at once in revertive mode
  wire move = !hold && any_valid && (best != sel_q) && (!sel_ok || revert);

  ////////////////////////////////////////////////////////////////////////
  // Selection register
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= '0;
      changed_q <= 1'b0;
    end else begin
      if (move) begin
        sel_q <= best;
      end
      changed_q <= move;
    end
  end
endmodule
`default_nettype wire

// ===== core/sec_tick.sv
`timescale 1ns/10ps
`default_nettype none
// Free-running divider: one-cycle pulse every CYCLES clocks
module sec_tick #(
  parameter int CYCLES = 20_000_000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Enable pulse
  output logic tick
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q; // Cycle counter
  wire wrap = (cnt_q == LAST);

  ////////////////////////////////////////////////////////////////////////
  // Count and wrap; tick is registered so it is clean from reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// ===== dv/dpll_state_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dpll_state_chk
  import dpll_pkg::*;
#(
  parameter int N = 8,
  parameter int TICK = 20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic [dpll_pkg::AW-1:0] ADDR,
  input wire logic [dpll_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [dpll_pkg::DW-1:0] RDATA,
  // Monitors
  input wire logic [N-1:0] ACT_ALARM,
  input wire logic PHASE_LOCK,
  input wire logic LOSS_OF_LOCK,
  input wire logic FAST_FAIL,
  // State outputs
  input wire logic LOCK,
  input wire logic [2:0] STATE,
  input wire logic [$clog2(N)-1:0] SEL_REF,
  input wire logic [N-1:0] INPUT_VALID,
  input wire logic TRACK_REF,
  input wire logic HOLDOVER,
  input wire logic FREE_RUN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////
  // Run of cycles with the lock detector high
  logic [31:0] lock_run_q;
  // Run of cycles with the selected input invalid; a gap restarts it
  logic [31:0] bad_run_q;
  // Lock detector run length
  always_ff @(posedge CLK) begin
    if (RST || !PHASE_LOCK) begin
      lock_run_q <= '0;
    end else begin
      lock_run_q <= lock_run_q + 32'h1;
    end
  end
  // Selected-input invalid run; in loss-of-lock other inputs may come
  // and go during the wait, so only the selected one is measured
  always_ff @(posedge CLK) begin
    if (RST || INPUT_VALID[SEL_REF]) begin
      bad_run_q <= '0;
    end else begin
      bad_run_q <= bad_run_q + 32'h1;
    end
  end
  ////////////////////////////////////////////////
  // Automatic entry into locked
  sequence into_lock;
    (STATE inside {ST_PRE, ST_LOL, ST_PRE2}) && !WR ##1 STATE == ST_LOCKED;
  endsequence
  // Automatic entry into holdover
  sequence into_hold;
    STATE != ST_HOLD && !WR ##1 STATE == ST_HOLD;
  endsequence
  ////////////////////////////////////////////////
  state_legal_a: assert property (STATE < NUM_STATES)
    else $error("state code out of range");
  reset_free_a: assert property ($fell(RST) |-> STATE == ST_FREE)
    else $error("not free-run after reset");
  free_pre_a: assert property (STATE == ST_FREE && (|INPUT_VALID)
    && !WR |=> STATE == ST_PRE)
    else $error("free-run ignored a valid input");
  lol_enter_a: assert property (STATE == ST_LOCKED && LOSS_OF_LOCK
    && !FAST_FAIL && !WR && INPUT_VALID[SEL_REF] |=> STATE == ST_LOL)
    else $error("loss of lock not entered");
  lock_pin_a: assert property (LOCK |-> $past(STATE) == ST_LOCKED)
    else $error("lock pin high outside locked");
  valid_def_a: assert property ((INPUT_VALID & ACT_ALARM) == '0)
    else $error("input valid despite activity alarm");
  read_state_a: assert property (RD && ADDR == ADDR_OPSTATUS
    |=> RDATA == {13'h0, $past(STATE)}) else $error("state readback wrong");
  hold_pre2_a: assert property (STATE == ST_HOLD && (|INPUT_VALID)
    && !WR |=> STATE == ST_PRE2)
    else $error("holdover ignored a valid input");
  force_state_a: assert property (WR && ADDR == ADDR_MODE_ONE
    && WDATA[3] && WDATA[2:0] < NUM_STATES |=> STATE == $past(WDATA[2:0]))
    else $error("forced state not taken");
  lock_hold_a: assert property (into_lock
    |-> $past(lock_run_q) >= TICK)
    else $error("locked entered without held lock");
  hold_wait_a: assert property (into_hold
    |-> $past(bad_run_q) >= TICK)
    else $error("holdover entered too early");
  fast_sw_a: assert property ((STATE inside {ST_LOCKED, ST_LOL})
    && FAST_FAIL && !WR |=> STATE != ST_LOL) else $error("fast switch via lol");
endmodule
bind dpll_state_ctrl dpll_state_chk #(.N(N), .TICK(TICK)) i_dpll_state_chk (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .ACT_ALARM(ACT_ALARM), .PHASE_LOCK(PHASE_LOCK),
  .LOSS_OF_LOCK(LOSS_OF_LOCK), .FAST_FAIL(FAST_FAIL), .LOCK(LOCK),
  .STATE(STATE), .SEL_REF(SEL_REF), .INPUT_VALID(INPUT_VALID),
  .TRACK_REF(TRACK_REF), .HOLDOVER(HOLDOVER), .FREE_RUN(FREE_RUN)
);
`default_nettype wire

// ===== dv/dpll_state_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dpll_state_ctrl_tb;
  import dpll_pkg::*;
  // Short second keeps the run brief
  localparam int TK = 20;
  logic CLK, RST, WR, RD, LOCK, TRACK_REF, HOLDOVER, FREE_RUN;
  logic [AW-1:0] ADDR;
  logic [DW-1:0] WDATA, RDATA;
  logic [7:0] ACT_ALARM, INPUT_VALID, act;
  logic PHASE_LOCK, LOSS_OF_LOCK, FAST_FAIL, lk, lol, ff, slow;
  logic [2:0] STATE, SEL_REF;
  logic [15:0] rnd;
  int n_fail, cmp_count;
  ////////////////////////////////////////////////
  dpll_state_ctrl #(.N(8), .TICK(TK)) i_dpll_state_ctrl (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ACT_ALARM(ACT_ALARM), .PHASE_LOCK(PHASE_LOCK),
    .LOSS_OF_LOCK(LOSS_OF_LOCK), .FAST_FAIL(FAST_FAIL), .LOCK(LOCK),
    .STATE(STATE), .SEL_REF(SEL_REF), .INPUT_VALID(INPUT_VALID),
    .TRACK_REF(TRACK_REF), .HOLDOVER(HOLDOVER), .FREE_RUN(FREE_RUN));
  mon_model #(.N(8)) i_mon_model (.clk(CLK), .act_cmd(act), .lock_cmd(lk),
    .lol_cmd(lol), .ff_cmd(ff), .slow(slow), .act_alarm(ACT_ALARM),
    .phase_lock(PHASE_LOCK), .loss_of_lock(LOSS_OF_LOCK),
    .fast_fail(FAST_FAIL));
  // 50 ns period
  always #25 CLK = ~CLK;
  ////////////////////////////////////////////////
  // Highest priority valid input is the lowest index
  function automatic logic [15:0] best(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      if (v[i]) return 16'(i);
    end
    return 16'h0;
  endfunction
  // Repeatable pseudo-random words
  function automatic logic [15:0] xs(input logic [15:0] s);
    s ^= s << 7;
    s ^= s >> 9;
    s ^= s << 8;
    return s;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    // Step off the edge so a following write raises WR in a later step
    #1;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rck(input logic [AW-1:0] a, input logic [DW-1:0] e,
                     input string nm);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(nm, e, RDATA);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // Bounded wait for a state, then compare
  task automatic wait_st(input logic [2:0] e, input int mx);
    for (int i = 0; i < mx && STATE !== e; i++) begin
      @(posedge CLK);
      #1;
    end
    chk("STATE", 16'(e), 16'(STATE));
  endtask
  task automatic tend(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////
  // Hang guard, well beyond the expected run length
  initial begin
    repeat (6000) @(posedge CLK);
    n_fail++;
    test_done();
  end
  // Main sequence
  initial begin
    CLK = 0; RST = 1; WR = 0; RD = 0; ADDR = '0; WDATA = '0;
    act = 8'hff; lk = 0; lol = 0; ff = 0; slow = 0; rnd = 16'h001f;
    n_fail = 0; cmp_count = 0;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    cyc(1);
    chk("STATE", 16'(ST_FREE), 16'(STATE));
    chk("FREE_RUN", 16'h1, 16'(FREE_RUN));
    rck(ADDR_MODE_ONE, 16'h0, "mode_one");
    rck(ADDR_MODE_THREE, 16'h0, "mode_three");
    rck(ADDR_TIMEOUT, TIMEOUT_RST, "timeout");
    rck(ADDR_OPSTATUS, 16'h0, "opstatus");
    rck(5'h1c, 16'h0, "unmapped");
    for (int k = 0; k < 6; k++) begin
      rnd = xs(rnd);
      wr(ADDR_TIMEOUT, rnd);
      rck(ADDR_TIMEOUT, rnd, "timeout");
    end
    wr(ADDR_TIMEOUT, 16'h0004);
    wr(ADDR_LATCHED_TWO, 16'h0001);
    tend("reset");
    // Free-run leaves on one valid input; revertive picks a better one
    act <= 8'hfb;
    wait_st(ST_PRE, 4);
    cyc(2);
    chk("SEL_REF", best(~act), 16'(SEL_REF));
    rck(ADDR_LATCHED_TWO, 16'h0001, "latched");
    wr(ADDR_LATCHED_TWO, 16'h0001);
    rck(ADDR_LATCHED_TWO, 16'h0000, "latched");
    wr(ADDR_MODE_THREE, 16'h0001);
    act <= 8'hf9;
    cyc(4);
    chk("SEL_REF", best(~act), 16'(SEL_REF));
    chk("STATE", 16'(ST_PRE), 16'(STATE));
    wr(ADDR_MODE_THREE, 16'h0000);
    tend("prelocked");
    // Lock, lock pin, loss of lock and relock
    lk <= 1'b1;
    wait_st(ST_LOCKED, 4 * TK);
    wr(ADDR_MODE_ONE, 16'h0010);
    cyc(2);
    chk("LOCK", 16'h1, 16'(LOCK));
    chk("TRACK_REF", 16'h1, 16'(TRACK_REF));
    lol <= 1'b1;
    lk <= 1'b0;
    wait_st(ST_LOL, 4);
    cyc(2);
    chk("LOCK", 16'h0, 16'(LOCK));
    lol <= 1'b0;
    lk <= 1'b1;
    wait_st(ST_LOCKED, 4 * TK);
    tend("locked");
    // Selected input fails fast; another is valid; slow detector
    slow <= 1'b1;
    act <= 8'hfb;
    ff <= 1'b1;
    @(posedge CLK);
    ff <= 1'b0;
    wait_st(ST_PRE2, 4);
    cyc(2);
    chk("SEL_REF", best(~act), 16'(SEL_REF));
    wait_st(ST_LOCKED, 4 * TK);
    tend("prelocked2");
    // Everything lost: holdover, then any valid input leaves it
    act <= 8'hff;
    lk <= 1'b0;
    wait_st(ST_HOLD, 4 * TK);
    cyc(2);
    chk("HOLDOVER", 16'h1, 16'(HOLDOVER));
    act <= 8'hf7;
    wait_st(ST_PRE2, 4);
    cyc(2);
    chk("SEL_REF", best(~act), 16'(SEL_REF));
    // Acquisition timeout raises the lock alarm and invalidates
    wait_st(ST_HOLD, 10 * TK);
    chk("INPUT_VALID", 16'h0, 16'(INPUT_VALID));
    rck(ADDR_ALARMS, 16'hf708, "alarms");
    wr(ADDR_ALARMS, 16'h0008);
    wait_st(ST_PRE2, 4);
    tend("holdover");
    // Every state code forced; an illegal code is ignored
    act <= 8'hff;
    for (int c = 0; c < 6; c++) begin
      wr(ADDR_MODE_ONE, 16'(8 + c));
      #1;
      chk("STATE", 16'(c), 16'(STATE));
    end
    wr(ADDR_MODE_ONE, 16'h000e);
    #1;
    chk("STATE", 16'(ST_HOLD), 16'(STATE));
    rck(ADDR_OPSTATUS, 16'(ST_HOLD), "opstatus");
    rck(ADDR_LATCHED_TWO, 16'h0001, "latched");
    tend("force");
    test_done();
  end
endmodule
`default_nettype wire

// ===== dv/mon_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the clock monitors and lock detectors
module mon_model #(
  parameter int N = 8
) (
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic [N-1:0] act_cmd,
  input wire logic lock_cmd,
  input wire logic lol_cmd,
  input wire logic ff_cmd,
  input wire logic slow,
  // Towards the state machine
  output logic [N-1:0] act_alarm,
  output logic phase_lock,
  output logic loss_of_lock,
  output logic fast_fail
);
  // Extra stage: a slow detector declares lock one cycle later
  logic lock_d1_q;
  // All monitor outputs change just after the edge, like real flops
  always_ff @(posedge clk) begin
    act_alarm <= act_cmd;
    lock_d1_q <= lock_cmd;
    phase_lock <= slow ? lock_d1_q : lock_cmd;
    loss_of_lock <= lol_cmd;
    fast_fail <= ff_cmd;
  end
endmodule
`default_nettype wire
